//--- pkg/ptmr_defs.vh
`ifndef PTMR_DEFS_VH
`define PTMR_DEFS_VH

// ----------------------------------------------------------------
// register addresses
// ----------------------------------------------------------------
`define PTMR_ADDR_CTRL0 3'h0
`define PTMR_ADDR_CTRL1 3'h1
`define PTMR_ADDR_CNTL 3'h2
`define PTMR_ADDR_CNTH 3'h3
`define PTMR_ADDR_CMPAL 3'h4
`define PTMR_ADDR_CMPAH 3'h5
`define PTMR_ADDR_CMPPL 3'h6
`define PTMR_ADDR_CMPPH 3'h7

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define PTMR_C0_HOLD 7
`define PTMR_C0_CKSEL_HI 6
`define PTMR_C0_CKSEL_LO 4
`define PTMR_C0_RUN 3
`define PTMR_C1_OPSEL_HI 7
`define PTMR_C1_OPSEL_LO 6
`define PTMR_C1_PIN_HI 5
`define PTMR_C1_PIN_LO 4
`define PTMR_C1_OLVL 3
`define PTMR_C1_INV 2
`define PTMR_C1_CAPSRC 1
`define PTMR_C1_CLRSRC 0
`define PTMR_C0_MASK 8'hf8

// ----------------------------------------------------------------
// reset values and encodings
// ----------------------------------------------------------------
`define PTMR_RST_BYTE 8'h00
`define PTMR_RST_CNT 10'h000
`define PTMR_CNT_MAX 10'h3ff
`define PTMR_MODE_CMP 2'h0
`define PTMR_MODE_CAP 2'h1
`define PTMR_MODE_PWM 2'h2
`define PTMR_MODE_TMR 2'h3
`define PTMR_CK_SYS4 3'h0
`define PTMR_CK_HI 3'h1
`define PTMR_CK_HI16 3'h2
`define PTMR_CK_HI64 3'h3
`define PTMR_CK_TBC0 3'h4
`define PTMR_CK_TBC1 3'h5
`define PTMR_CK_EXTR 3'h6
`define PTMR_CK_EXTF 3'h7

// ----------------------------------------------------------------
// timing counts: prescaler terminal values, in source ticks (system clock for SYS4, high clock for HI16/HI64)
// ----------------------------------------------------------------
`define PTMR_DIV_SYS4 6'h03
`define PTMR_DIV_HI16 6'h0f
`define PTMR_DIV_HI64 6'h3f

`endif

//--- logic/ptmr_edge.v
`timescale 1ns/1ps
// ----------------------------------------------------------------
// registered edge detector for a synchronous input
// ----------------------------------------------------------------
module ptmr_edge (
  mclk,
  rst,
  sig,
  rise,
  fall
);
  input wire mclk;
  input wire rst;
  input wire sig;
  output wire rise;
  output wire fall;

  reg last;

  // remember previous level; inputs are already synchronous
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      last <= 1'b0;
    end else begin
      last <= sig;
    end
  end

  assign rise = sig & ~last;
  assign fall = ~sig & last;
endmodule // ptmr_edge

//--- logic/ptmr_prescale.v
`timescale 1ns/1ps
`include "ptmr_defs.vh"
// ----------------------------------------------------------------
// divider that turns clock enables into slower enables
// ----------------------------------------------------------------
module ptmr_prescale (
  mclk,
  rst,
  src_tick,
  div_last,
  run,
  tick
);
  input wire mclk;
  input wire rst;
  input wire src_tick;
  input wire [5:0] div_last;
  input wire run;
  output wire tick;

  reg [5:0] cnt;

  // divider restarts while timer is off so the first period is full
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      cnt <= 6'h00;
    end else if (!run) begin
      cnt <= 6'h00;
    end else if (src_tick) begin
      if (cnt >= div_last) begin
        cnt <= 6'h00;
      end else begin
        cnt <= cnt + 6'h01;
      end
    end
  end

  assign tick = run & src_tick & (cnt >= div_last);
endmodule // ptmr_prescale

//--- logic/ptmr_top.v
`timescale 1ns/1ps
`include "ptmr_defs.vh"
module ptmr_top (
  mclk,
  rst,
  reg_addr,
  reg_wdata,
  reg_wr,
  reg_rd,
  reg_rdata,
  high_clk_tick,
  timebase_tick,
  ext_clock_pin,
  timer_out_pin_0,
  timer_out_pin_1,
  match_a_flag,
  match_p_flag,
  capture_event
);
  input wire mclk;
  input wire rst;
  input wire [2:0] reg_addr;
  input wire [7:0] reg_wdata;
  input wire reg_wr;
  input wire reg_rd;
  output reg [7:0] reg_rdata;
  input wire high_clk_tick;
  input wire timebase_tick;
  input wire ext_clock_pin;
  output reg timer_out_pin_0;
  output reg timer_out_pin_1;
  output reg match_a_flag;
  output reg match_p_flag;
  output reg capture_event;

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  reg counter_hold;
  reg [2:0] clock_select;
  reg counter_run;
  reg [1:0] operation_select;
  reg [1:0] pin_action_select;
  reg output_level_select;
  reg output_invert;
  reg capture_source_select;
  reg clear_source_select;
  reg [9:0] compare_a_value;
  reg [9:0] compare_p_value;
  reg [9:0] count;
  reg [7:0] byte_buf;
  reg run_last;
  reg pin_level;
  reg pulse_armed;

  wire run_rise;
  wire wr_c0;
  wire wr_c1;
  wire sys4_tick;
  wire hi16_tick;
  wire hi64_tick;
  wire ext_rise;
  wire ext_fall;
  wire out_rise;
  wire out_fall;
  wire cap_rise;
  wire cap_fall;
  reg cnt_tick;
  reg [9:0] next_count;
  reg next_pin_level;
  reg next_pulse_armed;
  reg match_a;
  reg match_p;
  reg do_clear;
  reg cap_hit;
  reg pwm_active;
  reg [7:0] next_rdata;
  reg out_raw;

  assign wr_c0 = reg_wr && (reg_addr == `PTMR_ADDR_CTRL0);
  assign wr_c1 = reg_wr && (reg_addr == `PTMR_ADDR_CTRL1);
  assign run_rise = counter_run & ~run_last;

  // ----------------------------------------------------------------
  // clock source selection
  // ----------------------------------------------------------------
  ptmr_prescale u_sys4 (
    .mclk(mclk),
    .rst(rst),
    .src_tick(1'b1),
    .div_last(`PTMR_DIV_SYS4),
    .run(counter_run),
    .tick(sys4_tick)
  );
  ptmr_prescale u_hi16 (
    .mclk(mclk),
    .rst(rst),
    .src_tick(high_clk_tick),
    .div_last(`PTMR_DIV_HI16),
    .run(counter_run),
    .tick(hi16_tick)
  );
  ptmr_prescale u_hi64 (
    .mclk(mclk),
    .rst(rst),
    .src_tick(high_clk_tick),
    .div_last(`PTMR_DIV_HI64),
    .run(counter_run),
    .tick(hi64_tick)
  );
  ptmr_edge u_ext (
    .mclk(mclk),
    .rst(rst),
    .sig(ext_clock_pin),
    .rise(ext_rise),
    .fall(ext_fall)
  );
  // capture looks at the pin level as driven, before it leaves
  ptmr_edge u_outp (
    .mclk(mclk),
    .rst(rst),
    .sig(timer_out_pin_0),
    .rise(out_rise),
    .fall(out_fall)
  );

  // tick mux; external edges count events
  always @* begin
    case (clock_select)
      `PTMR_CK_SYS4: cnt_tick = sys4_tick;
      `PTMR_CK_HI: cnt_tick = high_clk_tick;
      `PTMR_CK_HI16: cnt_tick = hi16_tick;
      `PTMR_CK_HI64: cnt_tick = hi64_tick;
      `PTMR_CK_TBC0: cnt_tick = timebase_tick;
      `PTMR_CK_TBC1: cnt_tick = timebase_tick;
      `PTMR_CK_EXTR: cnt_tick = ext_rise;
      `PTMR_CK_EXTF: cnt_tick = ext_fall;
      default: cnt_tick = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // counter, comparators and clear
  // ----------------------------------------------------------------
  // matches only count while running so a stopped timer stays silent
  always @* begin
    match_a = counter_run && (count == compare_a_value);
    match_p = counter_run && (count == compare_p_value);
    // pwm and capture always clear on P; bit ignored there
    if (clear_source_select && (operation_select == `PTMR_MODE_CMP ||
        operation_select == `PTMR_MODE_TMR)) begin
      do_clear = match_a;
    end else begin
      do_clear = match_p && (compare_p_value != `PTMR_RST_CNT);
    end
    next_count = count;
    if (run_rise) begin
      next_count = `PTMR_RST_CNT;
    end else if (counter_run && !counter_hold && cnt_tick) begin
      // P at zero lets the count wrap, acting as overflow clear
      if (do_clear) begin
        next_count = `PTMR_RST_CNT;
      end else begin
        next_count = count + 10'h001;
      end
    end
  end

  // ----------------------------------------------------------------
  // output pin logic
  // ----------------------------------------------------------------
  always @* begin
    next_pin_level = pin_level;
    next_pulse_armed = pulse_armed;
    pwm_active = 1'b0;
    cap_hit = 1'b0;
    case (operation_select)
      `PTMR_MODE_CMP: begin
        if (run_rise) begin
          next_pin_level = output_level_select;
        end else if (match_a && cnt_tick && !counter_hold) begin
          // only A moves the pin; same level gives no edge
          case (pin_action_select)
            2'h1: next_pin_level = 1'b0;
            2'h2: next_pin_level = 1'b1;
            2'h3: next_pin_level = ~pin_level;
            default: next_pin_level = pin_level;
          endcase
        end
      end
      `PTMR_MODE_PWM: begin
        // duty above period gives full active time; duty equal to P leaves count P inactive
        pwm_active = (count < compare_a_value);
        if (run_rise) begin
          next_pulse_armed = 1'b1;
        end else if (match_a && cnt_tick) begin
          next_pulse_armed = 1'b0;
        end
        case (pin_action_select)
          2'h0: next_pin_level = ~output_level_select;
          2'h1: next_pin_level = output_level_select;
          2'h2: next_pin_level = pwm_active ? output_level_select :
                                 ~output_level_select;
          default: next_pin_level = (pulse_armed && counter_run) ?
                   output_level_select : ~output_level_select;
        endcase
      end
      `PTMR_MODE_CAP: begin
        case (pin_action_select)
          2'h0: cap_hit = cap_rise;
          2'h1: cap_hit = cap_fall;
          2'h2: cap_hit = cap_rise | cap_fall;
          default: cap_hit = 1'b0;
        endcase
      end
      default: next_pin_level = pin_level;
    endcase
    // invert ignored in timer/counter mode
    if (output_invert && operation_select != `PTMR_MODE_TMR) begin
      out_raw = ~next_pin_level;
    end else begin
      out_raw = next_pin_level;
    end
  end

  // capture trigger from pin 0 level or external pin
  assign cap_rise = capture_source_select ? ext_rise : out_rise;
  assign cap_fall = capture_source_select ? ext_fall : out_fall;

  // ----------------------------------------------------------------
  // register read mux
  // ----------------------------------------------------------------
  always @* begin
    next_rdata = `PTMR_RST_BYTE;
    case (reg_addr)
      `PTMR_ADDR_CTRL0: next_rdata = {counter_hold, clock_select,
                                      counter_run, 3'h0};
      `PTMR_ADDR_CTRL1: next_rdata = {operation_select, pin_action_select,
                                      output_level_select, output_invert,
                                      capture_source_select,
                                      clear_source_select};
      `PTMR_ADDR_CNTL: next_rdata = byte_buf;
      `PTMR_ADDR_CNTH: next_rdata = {6'h00, count[9:8]};
      `PTMR_ADDR_CMPAL: next_rdata = byte_buf;
      `PTMR_ADDR_CMPAH: next_rdata = {6'h00, compare_a_value[9:8]};
      `PTMR_ADDR_CMPPL: next_rdata = byte_buf;
      `PTMR_ADDR_CMPPH: next_rdata = {6'h00, compare_p_value[9:8]};
      default: next_rdata = `PTMR_RST_BYTE;
    endcase
  end

  // ----------------------------------------------------------------
  // registers and bus slave
  // ----------------------------------------------------------------
  // mode changes while running are software's hazard, not blocked
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      counter_hold <= 1'b0;
      clock_select <= 3'h0;
      counter_run <= 1'b0;
      operation_select <= 2'h0;
      pin_action_select <= 2'h0;
      output_level_select <= 1'b0;
      output_invert <= 1'b0;
      capture_source_select <= 1'b0;
      clear_source_select <= 1'b0;
      compare_a_value <= `PTMR_RST_CNT;
      compare_p_value <= `PTMR_RST_CNT;
      byte_buf <= `PTMR_RST_BYTE;
      reg_rdata <= `PTMR_RST_BYTE;
    end else begin
      reg_rdata <= reg_rd ? next_rdata : `PTMR_RST_BYTE;
      if (wr_c0) begin
        counter_hold <= reg_wdata[`PTMR_C0_HOLD];
        clock_select <= reg_wdata[`PTMR_C0_CKSEL_HI:`PTMR_C0_CKSEL_LO];
        counter_run <= reg_wdata[`PTMR_C0_RUN];
      end
      if (wr_c1) begin
        operation_select <= reg_wdata[`PTMR_C1_OPSEL_HI:`PTMR_C1_OPSEL_LO];
        pin_action_select <= reg_wdata[`PTMR_C1_PIN_HI:`PTMR_C1_PIN_LO];
        output_level_select <= reg_wdata[`PTMR_C1_OLVL];
        output_invert <= reg_wdata[`PTMR_C1_INV];
        capture_source_select <= reg_wdata[`PTMR_C1_CAPSRC];
        clear_source_select <= reg_wdata[`PTMR_C1_CLRSRC];
      end
      // compare low writes only fill the shared buffer
      if (reg_wr && (reg_addr == `PTMR_ADDR_CMPAL ||
          reg_addr == `PTMR_ADDR_CMPPL)) begin
        byte_buf <= reg_wdata;
      end else if (reg_wr && reg_addr == `PTMR_ADDR_CMPAH) begin
        compare_a_value <= {reg_wdata[1:0], byte_buf};
      end else if (reg_wr && reg_addr == `PTMR_ADDR_CMPPH) begin
        compare_p_value <= {reg_wdata[1:0], byte_buf};
      end else if (reg_rd) begin
        // high reads snapshot the low byte for a coherent pair
        case (reg_addr)
          `PTMR_ADDR_CNTH: byte_buf <= count[7:0];
          `PTMR_ADDR_CMPAH: byte_buf <= compare_a_value[7:0];
          `PTMR_ADDR_CMPPH: byte_buf <= compare_p_value[7:0];
          default: byte_buf <= byte_buf;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // timer state and outputs
  // ----------------------------------------------------------------
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      count <= `PTMR_RST_CNT;
      run_last <= 1'b0;
      pin_level <= 1'b0;
      pulse_armed <= 1'b0;
      timer_out_pin_0 <= 1'b0;
      timer_out_pin_1 <= 1'b0;
      match_a_flag <= 1'b0;
      match_p_flag <= 1'b0;
      capture_event <= 1'b0;
    end else begin
      count <= next_count;
      run_last <= counter_run;
      pin_level <= next_pin_level;
      pulse_armed <= next_pulse_armed;
      timer_out_pin_0 <= out_raw;
      // second pin is the complement for a complementary pair
      timer_out_pin_1 <= ~out_raw;
      // P flag is suppressed when A owns the clear in compare and timer/counter modes
      match_a_flag <= match_a && cnt_tick && !counter_hold;
      match_p_flag <= match_p && cnt_tick && !counter_hold &&
                      !(clear_source_select &&
                        operation_select[0] == operation_select[1]);
      capture_event <= cap_hit && counter_run;
    end
  end
endmodule // ptmr_top

//--- dv/ptmr_properties.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// port checker for the periodic timer
// ----------------------------------------------------------------
module ptmr_properties (
  input wire mclk,
  input wire rst,
  input wire [2:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_rdata,
  input wire timer_out_pin_0,
  input wire timer_out_pin_1,
  input wire match_a_flag,
  input wire match_p_flag,
  input wire capture_event
);
  reg [7:0] sh0;
  reg [7:0] sh1;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // shadow copies of both control registers, taken from bus writes
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      sh0 <= 8'h00;
      sh1 <= 8'h00;
    end else if (reg_wr && reg_addr == 3'h0) begin
      sh0 <= reg_wdata;
    end else if (reg_wr && reg_addr == 3'h1) begin
      sh1 <= reg_wdata;
    end
  end
  rd_idle_a: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data not zero outside a read");
  pin_pair_a: assert property (!$past(rst) |->
    timer_out_pin_1 == !timer_out_pin_0) else $error("pins not paired");
  ctrl0_rsvd_a: assert property (
    reg_rd && reg_addr == 3'h0 |=> reg_rdata[2:0] == 3'h0)
    else $error("ctrl0 low bits not zero");
  high_rsvd_a: assert property (
    reg_rd && reg_addr[0] && reg_addr != 3'h1 |=> reg_rdata[7:2] == 6'h00)
    else $error("high byte upper bits not zero");
  ctrl1_back_a: assert property (
    reg_wr && reg_addr == 3'h1 ##1 reg_rd && reg_addr == 3'h1
    |=> reg_rdata == $past(reg_wdata, 2)) else $error("ctrl1 readback");
  cmp_pair_a: assert property (
    reg_wr && reg_addr == 3'h4 ##1 reg_wr && reg_addr == 3'h5 ##1
    reg_rd && reg_addr == 3'h5 ##1 reg_rd && reg_addr == 3'h4
    |=> reg_rdata == $past(reg_wdata, 4)) else $error("low byte pair");
  stop_quiet_a: assert property (
    !sh0[3] && !$past(sh0[3]) |-> !match_a_flag && !match_p_flag)
    else $error("match flag while stopped");
  no_pflag_a: assert property (
    sh1[0] && sh1[7] == sh1[6] && $stable(sh1) |-> !match_p_flag)
    else $error("p flag while clearing on a");
  pin_by_a_a: assert property (
    sh1[7:6] == 2'b00 && $stable(sh1) && sh0[3] && $past(sh0[3]) &&
    $past(sh0[3], 2) && !$stable(timer_out_pin_0) |-> match_a_flag)
    else $error("pin moved without a match");
  capture_off_a: assert property (
    sh1[7:6] != 2'b01 && $stable(sh1) |-> !capture_event)
    else $error("capture outside capture mode");
endmodule // ptmr_properties

bind ptmr_top ptmr_properties ptmr_properties_i (.mclk(mclk), .rst(rst),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .timer_out_pin_0(timer_out_pin_0),
  .timer_out_pin_1(timer_out_pin_1), .match_a_flag(match_a_flag),
  .match_p_flag(match_p_flag), .capture_event(capture_event));

//--- dv/tb.sv
`timescale 1ns/1ps
module tb;
  reg mclk = 1'b0;
  reg rst = 1'b1;
  reg [2:0] reg_addr = 3'h0;
  reg [7:0] reg_wdata = 8'h00;
  reg reg_wr = 1'b0;
  reg reg_rd = 1'b0;
  reg high_clk_tick = 1'b0;
  reg timebase_tick = 1'b0;
  reg ext_clock_pin = 1'b0;
  wire [7:0] reg_rdata;
  wire timer_out_pin_0;
  wire timer_out_pin_1;
  wire match_a_flag;
  wire match_p_flag;
  wire capture_event;
  integer num_errors = 0;
  integer compares = 0;
  integer na = 0;
  integer np = 0;
  integer nc = 0;
  integer i, k, p, e, a0, p0;
  reg [31:0] seed = 32'h4598c53a;
  reg [7:0] d;
  reg [9:0] v;
  reg b;
  always #12.5 mclk = ~mclk;
  ptmr_top ptmr_top_i (.mclk(mclk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .high_clk_tick(high_clk_tick),
    .timebase_tick(timebase_tick), .ext_clock_pin(ext_clock_pin),
    .timer_out_pin_0(timer_out_pin_0), .timer_out_pin_1(timer_out_pin_1),
    .match_a_flag(match_a_flag), .match_p_flag(match_p_flag),
    .capture_event(capture_event));
  // ----------------------------------------------------------------
  // pulse tallies and helpers
  // ----------------------------------------------------------------
  always @(posedge mclk) begin
    na <= na + match_a_flag;
    np <= np + match_p_flag;
    nc <= nc + capture_event;
  end
  function [31:0] rnd(input integer u);
    begin
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      rnd = seed;
    end
  endfunction
  task chk(input string nm, input integer ex, input logic [15:0] got);
    begin
      compares = compares + 1;
      if (got !== ex[15:0]) begin
        num_errors = num_errors + 1;
        $display("BAD %s expected %0h seen %0h", nm, ex[15:0], got);
      end
    end
  endtask
  // bus strobes stay up between chained calls, so no double assignment
  task wr(input [2:0] ad, input [7:0] dt);
    begin
      reg_addr <= ad;
      reg_wdata <= dt;
      reg_rd <= 1'b0;
      reg_wr <= 1'b1;
      @(posedge mclk);
      #1;
    end
  endtask
  task rd(input [2:0] ad, output [7:0] q);
    begin
      reg_addr <= ad;
      reg_wr <= 1'b0;
      reg_rd <= 1'b1;
      @(posedge mclk);
      #1;
      q = reg_rdata;
    end
  endtask
  task rd16(input [2:0] hi, output [9:0] q);
    reg [7:0] lo;
    begin
      rd(hi, d);
      rd(hi - 3'h1, lo);
      chk("high rsvd", 0, {10'h0, d[7:2]});
      q = {d[1:0], lo};
    end
  endtask
  task idle(input integer n);
    begin
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      repeat (n) @(posedge mclk);
      #1;
    end
  endtask
  // each tick gives one source tick, one rising and one falling pin edge
  task tk(input integer n);
    integer j;
    begin
      for (j = 0; j < n; j = j + 1) begin
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        high_clk_tick <= 1'b1;
        timebase_tick <= 1'b1;
        ext_clock_pin <= 1'b1;
        @(posedge mclk);
        high_clk_tick <= 1'b0;
        timebase_tick <= 1'b0;
        repeat (3) @(posedge mclk);
        ext_clock_pin <= 1'b0;
        repeat (4) @(posedge mclk);
      end
      #1;
    end
  endtask
  task cfg(input [7:0] c1, input [7:0] c0);
    begin
      wr(3'h0, 8'h00);
      wr(3'h1, c1);
      wr(3'h0, c0);
      idle(2);
    end
  endtask
  task setcmp(input [2:0] hi, input [9:0] val);
    begin
      wr(hi - 3'h1, val[7:0]);
      wr(hi, {6'h0, val[9:8]});
    end
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    idle(1);
    wr(3'h3, 8'hff);
    wr(3'h2, 8'hff);
    for (i = 0; i < 2; i = i + 1) begin
      rd(i[2:0], d);
      chk("ctrl reset", 0, {8'h0, d});
    end
    for (i = 3; i < 8; i = i + 2) begin
      rd16(i[2:0], v);
      chk("pair reset", 0, {6'h0, v});
    end
    wr(3'h0, 8'h77);
    rd(3'h0, d);
    chk("ctrl0", 8'h70, {8'h0, d});
    k = rnd(0);
    wr(3'h1, k[7:0]);
    rd(3'h1, d);
    chk("ctrl1", k[7:0], {8'h0, d});
    wr(3'h4, k[7:0]);
    wr(3'h5, k[15:8]);
    rd16(3'h5, v);
    chk("cmp a", k[9:0], {6'h0, v});
    wr(3'h4, ~k[7:0]);
    rd16(3'h5, v);
    chk("cmp a held", k[9:0], {6'h0, v});
    // every clock source, stopped ticks must not count
    cfg(8'hc0, 8'h00);
    for (i = 0; i < 8; i = i + 1) begin
      p = (i == 2) ? 32 : (i == 3) ? 64 : 5;
      e = (i == 2) ? 2 : (i == 3) ? 1 : 5;
      wr(3'h0, {1'b0, i[2:0], 4'h8});
      // a tick on the run rise edge is lost to the restart clear
      idle(1);
      tk(p);
      wr(3'h0, {1'b0, i[2:0], 4'h0});
      tk(2);
      rd16(3'h3, v);
      if (i == 0)
        chk("count sys", 1, {15'h0, v >= 10'd9 && v <= 10'd11});
      else
        chk("count src", e, {6'h0, v});
    end
    wr(3'h0, 8'h18);
    idle(1);
    tk(3);
    wr(3'h0, 8'h98);
    tk(4);
    rd16(3'h3, v);
    chk("count hold", 3, {6'h0, v});
    wr(3'h0, 8'h18);
    tk(2);
    rd16(3'h3, v);
    chk("count resume", 5, {6'h0, v});
    wr(3'h0, 8'h10);
    wr(3'h0, 8'h18);
    idle(2);
    rd16(3'h3, v);
    chk("count restart", 0, {6'h0, v});
    tk(1026);
    rd16(3'h3, v);
    chk("count wrap", 2, {6'h0, v});
    // clear on comparator p, then on comparator a
    k = rnd(0);
    p = 3 + k[2:0];
    setcmp(3'h7, p[9:0]);
    setcmp(3'h5, 10'h001);
    a0 = na;
    p0 = np;
    cfg(8'hc0, 8'h18);
    tk(2 * p + 4);
    rd16(3'h3, v);
    chk("count p", (2 * p + 4) % (p + 1), {6'h0, v});
    e = np - p0;
    chk("flags p", 2, e[15:0]);
    e = na - a0;
    chk("flags a", 3, e[15:0]);
    setcmp(3'h5, 10'h004);
    setcmp(3'h7, 10'h002);
    a0 = na;
    p0 = np;
    cfg(8'hc1, 8'h18);
    tk(7);
    rd16(3'h3, v);
    chk("count a", 2, {6'h0, v});
    e = np - p0;
    chk("p suppressed", 0, e[15:0]);
    e = na - a0;
    chk("flag a once", 1, e[15:0]);
    // compare output: every pin action with both initial levels
    setcmp(3'h5, 10'h002);
    setcmp(3'h7, 10'h007);
    for (i = 0; i < 8; i = i + 1) begin
      k = rnd(0);
      cfg({2'b00, i[1:0], i[2], k[0], 2'b00}, 8'h18);
      chk("pin init", i[2] ^ k[0], {15'h0, timer_out_pin_0});
      chk("pin pair", !(i[2] ^ k[0]), {15'h0, timer_out_pin_1});
      tk(3);
      b = (i[1:0] == 2'd0) ? i[2] : (i[1:0] == 2'd3) ? !i[2] : i[1];
      chk("pin match", b ^ k[0], {15'h0, timer_out_pin_0});
    end
    // pwm and single pulse, active high; clear on A must stay ignored
    setcmp(3'h5, 10'h003);
    for (i = 0; i < 4; i = i + 1) begin
      cfg({2'b10, i[1:0], 4'h9}, 8'h18);
      chk("pwm start", i != 0, {15'h0, timer_out_pin_0});
      tk(4);
      chk("pwm later", i == 1, {15'h0, timer_out_pin_0});
    end
    // capture edges taken from the external pin
    for (i = 0; i < 4; i = i + 1) begin
      cfg({2'b01, i[1:0], 4'h2}, 8'h18);
      e = nc;
      tk(2);
      e = nc - e;
      chk("captures", (i == 3) ? 0 : (i == 2) ? 4 : 2, e[15:0]);
    end
    finish_test;
  end
  // watchdog well beyond the expected run length
  initial begin
    #1000000;
    num_errors = num_errors + 1;
    finish_test;
  end
  task finish_test;
    begin
      $display("errors %0d compares %0d", num_errors, compares);
      if (num_errors == 0 && compares > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask
endmodule // tb
